// [common/tbo_pkg.sv]
// constants for the 10base-t operations register
package tbo_pkg;
  localparam logic [4:0] TBO_ADDR = 5'h12;
  localparam int TBO_BIT_RJAB = 15;
  localparam int TBO_BIT_POLREV = 14;
  localparam int TBO_BIT_JABINH = 5;
  localparam int TBO_BIT_RSV1 = 4;
  localparam int TBO_BIT_APINH = 3;
  localparam int TBO_BIT_SQEINH = 2;
  localparam int TBO_BIT_LLINH = 1;
  localparam int TBO_BIT_SQLINH = 0;
  localparam logic [15:0] TBO_RESET = 16'h0010;
  localparam logic [15:0] TBO_RW_MASK = 16'h002F;
  localparam real TBO_SQE_DELAY_NS = 1000.0;
  localparam real TBO_SQE_WIDTH_NS = 1000.0;
  localparam real TBO_CLK_NS = 50.0;
  localparam int TBO_SQE_DELAY_CYC = int'($ceil(TBO_SQE_DELAY_NS / TBO_CLK_NS));
  localparam int TBO_SQE_WIDTH_CYC = int'($ceil(TBO_SQE_WIDTH_NS / TBO_CLK_NS));
  typedef enum logic [1:0] {TBO_SQE_IDLE, TBO_SQE_WAIT, TBO_SQE_PULSE}
    tbo_sqe_e;
endpackage

// [tb/tbo_ops_reg_asserts.sv]
// assertion checker for the 10base-t operations register
module tbo_ops_reg_asserts import tbo_pkg::*; (input wire logic i_mclk,
  input wire logic i_nrst, i_ce, i_reg_wr, i_reg_rd, i_rx_jabber,
  input wire logic [4:0] i_reg_addr, input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata, input wire logic i_full_duplex,
  input wire logic i_repeater, i_cable_inverted, o_jabber_check_en,
  input wire logic o_auto_pol_en, o_mdix_auto_ok, o_col_sqe, o_link_pass);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire rh = i_ce && i_reg_rd && i_reg_addr == TBO_ADDR;
  wire wh = i_ce && i_reg_wr && i_reg_addr == TBO_ADDR;
  rsv_bits_a: assert property (rh |=> o_reg_rdata[13:6] == 8'h00
    && o_reg_rdata[4]) else $error("reserved bits");
  rdata_hold_a: assert property (!rh |=> $stable(o_reg_rdata))
    else $error("rdata moved");
  jab_ctl_a: assert property (wh |=> o_jabber_check_en
    != $past(i_reg_wdata[5])) else $error("jabber enable");
  pol_ctl_a: assert property (wh |=> o_auto_pol_en
    != $past(i_reg_wdata[3])) else $error("polarity enable");
  mdix_ok_a: assert property (o_mdix_auto_ok != i_cable_inverted)
    else $error("crossover enable");
  sqe_mute_a: assert property (i_full_duplex || i_repeater |->
    !o_col_sqe) else $error("sqe not muted");
  link_force_a: assert property (wh && i_reg_wdata[1] |=>
    o_link_pass) else $error("link not forced");
  jab_latch_a: assert property (i_ce && i_rx_jabber ##1 rh |=>
    o_reg_rdata[15]) else $error("jabber flag lost");
  cover property (o_col_sqe);
  cover property (rh ##1 o_reg_rdata[15]);
  cover property (o_link_pass);
endmodule

// [tb/tbo_ops_reg_bench.sv]
// self-checking bench for the 10base-t operations register
module tbo_ops_reg_bench;
  import tbo_pkg::*;
  timeunit 1ns; timeprecision 1ns;
  logic i_mclk = 0, i_nrst = 0, i_ce = 1, i_idle_pattern = 1, i_tx_en = 0;
  logic i_rx_jabber = 0, i_rx_pol_reversed = 0, i_full_duplex = 0;
  logic i_repeater = 0, i_link_raw = 0, i_rx_valid_data = 0, i_reg_wr;
  logic i_cable_inverted = 0, i_reg_rd, o_col_sqe, o_link_pass;
  logic o_jabber_check_en, o_auto_pol_en, o_mdix_auto_ok;
  logic [4:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, v;
  int failures = 0, checks_done = 0, n;
  always #25 i_mclk = ~i_mclk;
  tbo_ops_reg dut (.*);
  tbo_sta sta (.i_clk(i_mclk), .i_rdata(o_reg_rdata), .o_addr(i_reg_addr),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));
  task chk(input string w, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", w, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task t_regs;
    sta.rd(TBO_ADDR, v); chk("reset", TBO_RESET, v);
    sta.wr(16'hFFFF); #1 chk("ctl", 1, {o_auto_pol_en, o_link_pass});
    sta.rd(TBO_ADDR, v); chk("rw", 16'h003F, v);
    sta.rd(5'h13, v); chk("unmapped", 16'h003F, v);
    sta.wr(16'h0); #1 chk("jab", 1, o_jabber_check_en);
  endtask
  task t_flags;
    @(posedge i_mclk) {i_rx_jabber, i_rx_pol_reversed} <= 2'b11;
    fork
      sta.rd(TBO_ADDR, v);
      @(posedge i_mclk) {i_rx_jabber, i_rx_pol_reversed} <= 2'b00;
    join
    chk("flags", 16'hC010, v);
    sta.rd(TBO_ADDR, v); chk("cleared", TBO_RESET, v);
  endtask
  task t_sqe;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) sta.wr(16'h0004);
      @(posedge i_mclk) {i_repeater, i_full_duplex, i_tx_en} <= {k[1:0], 1'b1};
      @(posedge i_mclk) i_tx_en <= 0;
      n = 0;
      repeat (60) @(negedge i_mclk) n += o_col_sqe;
      chk("sqe", k ? 0 : TBO_SQE_WIDTH_CYC, n);
    end
    sta.rd(TBO_ADDR, v); chk("inhibit", 16'h0014, v);
  endtask
  task t_link;
    @(posedge i_mclk) {i_link_raw, i_rx_valid_data} <= 2'b11;
    for (n = 0; n < 10 && o_link_pass !== 1; n++) @(negedge i_mclk);
    chk("link", 1, o_link_pass);
    @(posedge i_mclk) {i_link_raw, i_rx_valid_data, i_idle_pattern} <= 3'b000;
    sta.wr(16'h0001);
    @(posedge i_mclk) {i_link_raw, i_rx_valid_data} <= 2'b11;
    @(posedge i_mclk) i_rx_valid_data <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 chk("no idle", 0, o_link_pass);
    @(posedge i_mclk) i_idle_pattern <= 1'b1;
    @(posedge i_mclk);
    #1 chk("idle", 1, o_link_pass);
    @(posedge i_mclk) i_cable_inverted <= 1'b1;
    #1 chk("mdix", 0, o_mdix_auto_ok);
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1;
    t_regs; t_flags; t_sqe; t_link;
    wrap_up;
  end
endmodule
bind tbo_ops_reg tbo_ops_reg_asserts chk_i (.*);

// [tb/tbo_sta.sv]
// management station model issuing register reads and writes
module tbo_sta import tbo_pkg::*; (input wire logic i_clk,
  input wire logic [15:0] i_rdata, output logic [4:0] o_addr,
  output logic o_wr, o_rd, output logic [15:0] o_wdata);
  timeunit 1ns; timeprecision 1ns;
  initial {o_addr, o_wr, o_rd, o_wdata} = {TBO_ADDR, 2'b00, TBO_RESET};
  task wr(input logic [15:0] d);
    @(posedge i_clk) {o_addr, o_wr} <= {TBO_ADDR, 1'b1};
    o_wdata <= d & TBO_RW_MASK | TBO_RESET;
    @(posedge i_clk) o_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk) {o_addr, o_rd} <= {a, 1'b1};
    @(posedge i_clk) o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

// [verilog/tbo_ops_reg.sv]
// 10base-t operations register with sqe test and link controls
// Overview of operation
// - The register is a 16-bit word at management address 0x12.
// - Bit 15 latches high on receive jabber and clears on read or reset.
// - The remote jabber flag only informs and drives no corrective action.
// - Bit 14 latches high when the receive pair is seen reversed.
// - Receive keeps working normally whatever the reversal flag says.
// - Bit 5 set disables transmit jabber checking, clear enables it.
// - Bit 3 set inhibits automatic receive polarity correction.
// - Crossover auto-select is withheld on an inverted cable.
// - Bit 2 set disables sqe test generation, clear enables it.
// - With sqe test on, collision pulses briefly after transmit ends.
// - Sqe test is suppressed in full-duplex and repeater operation.
// - The sqe inhibit bit keeps its written value under suppression.
// - Bit 1 set forces link integrity into the link-passed state.
// - Bit 0 set requires valid data then idle before link comes up.
module tbo_ops_reg (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic i_rx_jabber,
  input wire logic i_rx_pol_reversed,
  input wire logic i_tx_en,
  input wire logic i_full_duplex,
  input wire logic i_repeater,
  input wire logic i_link_raw,
  input wire logic i_rx_valid_data,
  input wire logic i_idle_pattern,
  input wire logic i_cable_inverted,
  output logic o_jabber_check_en,
  output logic o_auto_pol_en,
  output logic o_mdix_auto_ok,
  output logic o_col_sqe,
  output logic o_link_pass
);
  import tbo_pkg::*;

  logic [15:0] ctrl_r;
  logic rjab_r;
  logic polrev_r;
  logic hit;
  logic rd_hit;
  logic tx_en_d_r;
  tbo_sqe_e sqe_st_r;
  logic [7:0] sqe_cnt_r;
  logic seen_data_r;
  logic link_r;

  assign hit = (i_reg_addr == TBO_ADDR);
  assign rd_hit = i_ce && hit && i_reg_rd;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r <= TBO_RESET;
    end else if (i_ce && hit && i_reg_wr) begin
      // reserved bits hold defaults; host writes them as such
      ctrl_r <= (i_reg_wdata & TBO_RW_MASK) | TBO_RESET;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rjab_r <= 1'b0;
      polrev_r <= 1'b0;
    end else if (i_ce) begin
      // new event wins over read clear
      rjab_r <= i_rx_jabber | (rjab_r & ~rd_hit);
      polrev_r <= i_rx_pol_reversed | (polrev_r & ~rd_hit);
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 16'h0000;
    end else if (rd_hit) begin
      o_reg_rdata <= {rjab_r, polrev_r, ctrl_r[13:0]};
    end
  end

  assign o_jabber_check_en = ~ctrl_r[TBO_BIT_JABINH];
  // polarity flag only reports; correction governed by bit 3
  assign o_auto_pol_en = ~ctrl_r[TBO_BIT_APINH];
  assign o_mdix_auto_ok = ~i_cable_inverted;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_en_d_r <= 1'b0;
    end else if (i_ce) begin
      tx_en_d_r <= i_tx_en;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sqe_st_r <= TBO_SQE_IDLE;
      sqe_cnt_r <= 8'h00;
    end else if (i_ce) begin
      case (sqe_st_r)
        TBO_SQE_IDLE: begin
          if (tx_en_d_r && !i_tx_en && !ctrl_r[TBO_BIT_SQEINH]
              && !i_full_duplex && !i_repeater) begin
            sqe_st_r <= TBO_SQE_WAIT;
            sqe_cnt_r <= 8'(TBO_SQE_DELAY_CYC - 1);
          end
        end
        TBO_SQE_WAIT: begin
          if (sqe_cnt_r == 8'h00) begin
            sqe_st_r <= TBO_SQE_PULSE;
            sqe_cnt_r <= 8'(TBO_SQE_WIDTH_CYC - 1);
          end else begin
            sqe_cnt_r <= sqe_cnt_r - 8'h01;
          end
        end
        TBO_SQE_PULSE: begin
          if (sqe_cnt_r == 8'h00) begin
            sqe_st_r <= TBO_SQE_IDLE;
          end else begin
            sqe_cnt_r <= sqe_cnt_r - 8'h01;
          end
        end
        default: begin
          sqe_st_r <= TBO_SQE_IDLE;
        end
      endcase
    end
  end

  assign o_col_sqe = (sqe_st_r == TBO_SQE_PULSE) && !i_full_duplex
    && !i_repeater;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      seen_data_r <= 1'b0;
      link_r <= 1'b0;
    end else if (i_ce) begin
      if (!i_link_raw) begin
        seen_data_r <= 1'b0;
        link_r <= 1'b0;
      end else if (!ctrl_r[TBO_BIT_SQLINH]) begin
        link_r <= link_r | i_rx_valid_data;
      end else begin
        if (i_rx_valid_data) begin
          seen_data_r <= 1'b1;
        end
        link_r <= link_r | (seen_data_r & i_idle_pattern);
      end
    end
  end

  assign o_link_pass = ctrl_r[TBO_BIT_LLINH] | link_r;
endmodule
